//--- src/gpm_pin_mux.sv
// Pin mux for pin_b0, pin_b1, pin_b4, pin_b5 with lamps and clock output.
// Assumes APB at 40 MHz, synchronous pad inputs, pad index 0..3 = b0,b1,b4,b5.
//
// Contract
// - Lamps flash fast 11.4 Hz or slow 2.8 Hz
// - Pins default GPIO input; limited alternate functions
// - Open-drain option drives low only, floats high
// - Weak pull-up option per pin
// - Inversion flips input and output paths
// - Drive strength 4 or 8 mA to pad
// - Only one pin carries the clock output
// - Divider zero holds clock output low
// - Divider 0xff holds clock output high
// - Otherwise clock is 24 MHz over divider+1
// - Divider writable at run time, reset loads 0xff
// - Suspend keeps driven levels by default
`timescale 1ns/1ps
`include "gpm_regs.svh"

module gpm_pin_mux
  import gpm_pkg::*;
#(
  parameter logic [22:0] LED_FAST_HALF =
    23'(`GPM_CLK_HZ * 64'd1000 / (64'd2 * `GPM_FAST_MILLIHZ)),
  parameter logic [22:0] LED_SLOW_HALF =
    23'(`GPM_CLK_HZ * 64'd1000 / (64'd2 * `GPM_SLOW_MILLIHZ))
)
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        TX_ACT_I,
  input  wire logic        RX_ACT_I,
  input  wire logic        SUSPEND_I,
  input  wire logic [3:0]  PAD_IN_I,
  output logic      [3:0]  PAD_OUT_O,
  output logic      [3:0]  PAD_OE_O,
  output logic      [3:0]  PAD_PU_O,
  output logic      [3:0]  PAD_DRV8_O
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [9:0]      func_r;
  gpm_pad_cfg_type pad_r;
  logic [7:0]      div_r;
  logic [3:0]      gout_r;
  logic [3:0]      gdir_r;
  gpm_fn_type      fn_b0;
  gpm_fn_type      fn_b1;
  logic            fn_b4;
  logic            led_slow;
  logic            susp_float;
  logic            wr_en;
  logic            rd_en;
  logic [31:0]     rd_data;
  logic            rd_err;

  assign fn_b0      = gpm_fn_type'(func_r[`GPM_F_B0_LSB +: 2]);
  assign fn_b1      = gpm_fn_type'(func_r[`GPM_F_B1_LSB +: 2]);
  assign fn_b4      = func_r[`GPM_F_B4_BIT];
  assign led_slow   = func_r[`GPM_F_SLOW_BIT];
  assign susp_float = func_r[`GPM_F_FLOAT_BIT];

  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // ----------------------------------------
  // APB write side
  // ----------------------------------------
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      func_r <= `GPM_FUNC_RST;
      pad_r  <= `GPM_PAD_RST;
      gout_r <= 4'h0;
      gdir_r <= 4'h0;
    end
    else if (wr_en)
    begin
      if (PADDR_I == `GPM_FUNC_OFS)
      begin
        func_r <= PWDATA_I[9:0];
      end
      else if (PADDR_I == `GPM_PAD_OFS)
      begin
        pad_r <= PWDATA_I[15:0];
      end
      else if (PADDR_I == `GPM_GPIO_OFS)
      begin
        gout_r <= PWDATA_I[3:0];
        gdir_r <= PWDATA_I[7:4];
      end
    end
  end

  // Divider may be rewritten at any time
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      div_r <= `GPM_DIV_RST;
    end
    else if (wr_en && PADDR_I == `GPM_DIV_OFS)
    begin
      div_r <= PWDATA_I[7:0];
    end
  end

  // ----------------------------------------
  // APB read side
  // ----------------------------------------
  logic       clk_lvl_r;
  logic       flash_r;
  logic [7:0] act_div_r;

  always_comb
  begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (PADDR_I == `GPM_FUNC_OFS)
    begin
      rd_data[9:0] = func_r;
    end
    else if (PADDR_I == `GPM_PAD_OFS)
    begin
      rd_data[15:0] = pad_r;
    end
    else if (PADDR_I == `GPM_DIV_OFS)
    begin
      rd_data[7:0]  = div_r;
      rd_data[15:8] = act_div_r;
    end
    else if (PADDR_I == `GPM_GPIO_OFS)
    begin
      rd_data[7:0] = {gdir_r, gout_r};
    end
    else if (PADDR_I == `GPM_STAT_OFS)
    begin
      rd_data[3:0] = PAD_IN_I ^ pad_r.inv;
      rd_data[4]   = clk_lvl_r;
      rd_data[5]   = flash_r;
      rd_data[6]   = SUSPEND_I;
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  // Answer in the access cycle that follows every setup cycle
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0;
    end
    else
    begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & rd_err;
      PRDATA_O  <= rd_en ? rd_data : 32'h0;
    end
  end

  // ----------------------------------------
  // 24 MHz tick from the 40 MHz clock
  // ----------------------------------------
  logic [5:0] acc_r;
  logic [5:0] acc_sum;
  logic       tick;

  assign acc_sum = acc_r + `GPM_SRC_MHZ;
  assign tick    = acc_sum >= `GPM_CLK_MHZ;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      acc_r <= 6'h0;
    end
    else
    begin
      acc_r <= tick ? acc_sum - `GPM_CLK_MHZ : acc_sum;
    end
  end

  // ----------------------------------------
  // Clock divider
  // ----------------------------------------
  logic [7:0] cnt_r;
  logic [8:0] half;
  logic       div_const;
  logic       at_edge;

  assign div_const = act_div_r == `GPM_DIV_LOW || act_div_r == `GPM_DIV_HIGH;
  assign at_edge   = div_const || (tick && cnt_r == act_div_r);
  assign half      = 9'({1'b0, act_div_r} + 9'h1) >> 1;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      cnt_r     <= 8'h0;
      act_div_r <= `GPM_DIV_RST;
    end
    else if (at_edge)
    begin
      cnt_r     <= 8'h0;
      act_div_r <= div_r;
    end
    else if (tick)
    begin
      cnt_r <= cnt_r + 8'h1;
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      clk_lvl_r <= 1'b1;
    end
    else if (act_div_r == `GPM_DIV_LOW)
    begin
      clk_lvl_r <= 1'b0;
    end
    else if (act_div_r == `GPM_DIV_HIGH)
    begin
      clk_lvl_r <= 1'b1;
    end
    else
    begin
      clk_lvl_r <= {1'b0, cnt_r} < half;
    end
  end

  // ----------------------------------------
  // Lamp flasher
  // ----------------------------------------
  logic [22:0] led_cnt_r;
  logic [22:0] led_lim;

  assign led_lim = led_slow ? LED_SLOW_HALF : LED_FAST_HALF;

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      led_cnt_r <= 23'h0;
      flash_r   <= 1'b0;
    end
    else if (led_cnt_r >= led_lim - 23'h1)
    begin
      led_cnt_r <= 23'h0;
      flash_r   <= ~flash_r;
    end
    else
    begin
      led_cnt_r <= led_cnt_r + 23'h1;
    end
  end

  // ----------------------------------------
  // Function select
  // ----------------------------------------
  logic [3:0] val;
  logic [3:0] drv;
  logic       send_activity_lamp;
  logic       receive_activity_lamp;
  logic       either_activity_lamp;

  assign send_activity_lamp    = TX_ACT_I & flash_r;
  assign receive_activity_lamp = RX_ACT_I & flash_r;
  assign either_activity_lamp  = (TX_ACT_I | RX_ACT_I) & flash_r;

  always_comb
  begin
    val = gout_r;
    drv = gdir_r;
    if (fn_b0 == GPM_FN_LAMP)
    begin
      val[0] = send_activity_lamp;
      drv[0] = 1'b1;
    end
    else if (fn_b0 == GPM_FN_ALT)
    begin
      val[0] = clk_lvl_r;
      drv[0] = 1'b1;
    end
    if (fn_b1 == GPM_FN_LAMP)
    begin
      val[1] = receive_activity_lamp;
      drv[1] = 1'b1;
    end
    else if (fn_b1 == GPM_FN_ALT)
    begin
      val[1] = either_activity_lamp;
      drv[1] = 1'b1;
    end
    // pin_b0 keeps the clock if both ask for it
    if (fn_b4 && fn_b0 != GPM_FN_ALT)
    begin
      val[2] = clk_lvl_r;
      drv[2] = 1'b1;
    end
  end

  // ----------------------------------------
  // Pad drivers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pad
      logic lvl;
      assign lvl = val[g] ^ pad_r.inv[g];

      always_ff @(posedge CLOCK_I)
      begin
        if (RST_I)
        begin
          PAD_OUT_O[g] <= 1'b0;
          PAD_OE_O[g]  <= 1'b0;
        end
        else if (SUSPEND_I && susp_float)
        begin
          PAD_OE_O[g] <= 1'b0;
        end
        else if (!SUSPEND_I)
        begin
          // Suspend with keep leaves both flops frozen
          if (pad_r.od[g])
          begin
            PAD_OUT_O[g] <= 1'b0;
            PAD_OE_O[g]  <= drv[g] & ~lvl;
          end
          else
          begin
            PAD_OUT_O[g] <= lvl;
            PAD_OE_O[g]  <= drv[g];
          end
        end
      end

      always_ff @(posedge CLOCK_I)
      begin
        if (RST_I)
        begin
          PAD_PU_O[g]   <= 1'b0;
          PAD_DRV8_O[g] <= 1'b0;
        end
        else
        begin
          PAD_PU_O[g]   <= pad_r.pu[g];
          PAD_DRV8_O[g] <= pad_r.drv8[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_wr_div;
    wr_en && PADDR_I == `GPM_DIV_OFS;
  endsequence

  sequence s_boundary;
    at_edge ##1 act_div_r == $past(div_r);
  endsequence

  AST_DIV_LOW: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    act_div_r == `GPM_DIV_LOW |=> !clk_lvl_r)
    else $error("clock output not low for divider zero");

  AST_DIV_HIGH: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    act_div_r == `GPM_DIV_HIGH |=> clk_lvl_r)
    else $error("clock output not high for divider 0xff");

  AST_DIV_CNT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !div_const && !tick |=> $stable(cnt_r))
    else $error("divider count moved without a source tick");

  AST_DIV_EDGE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !at_edge |=> $stable(act_div_r))
    else $error("divider changed inside a period");

  AST_DIV_WR: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_div |=> div_r == $past(PWDATA_I[7:0]))
    else $error("divider write lost");

  AST_DIV_LOAD: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    at_edge |-> s_boundary)
    else $error("boundary did not load divider");

  AST_LAMP_IDLE: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    fn_b0 == GPM_FN_LAMP && !TX_ACT_I && !SUSPEND_I && !pad_r.od[0]
    |=> PAD_OUT_O[0] == $past(pad_r.inv[0]))
    else $error("send lamp not idle without traffic");

  AST_LED_CNT: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !$stable(flash_r) |-> $past(led_cnt_r) >= $past(led_lim) - 23'h1)
    else $error("lamp toggled early");

  AST_OD_LOW: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    pad_r.od[0] && !SUSPEND_I |=> !(PAD_OE_O[0] && PAD_OUT_O[0]))
    else $error("open-drain pin driven high");

  AST_ONE_CLK: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    fn_b0 == GPM_FN_ALT |-> val[2] == gout_r[2])
    else $error("clock on two pins");

  AST_SUSP_KEEP: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    SUSPEND_I && !susp_float |=> $stable(PAD_OUT_O) && $stable(PAD_OE_O))
    else $error("pads changed during suspend");

  AST_RST_GPIO: assert property (@(posedge CLOCK_I)
    RST_I |=> func_r == `GPM_FUNC_RST && gdir_r == 4'h0)
    else $error("pins not GPIO inputs after reset");

endmodule : gpm_pin_mux

//--- src/gpm_regs.svh
// Register map, field positions, reset values and timing of the pin mux.
// Assumes a 32-bit APB slave with a byte address.
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define GPM_FUNC_OFS    8'h00
`define GPM_PAD_OFS     8'h04
`define GPM_DIV_OFS     8'h08
`define GPM_GPIO_OFS    8'h0c
`define GPM_STAT_OFS    8'h10

// ----------------------------------------
// Fields of the function register
// ----------------------------------------
`define GPM_F_B0_LSB    0
`define GPM_F_B1_LSB    2
`define GPM_F_B4_BIT    4
`define GPM_F_SLOW_BIT  8
`define GPM_F_FLOAT_BIT 9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPM_FUNC_RST    10'h000
`define GPM_PAD_RST     16'h0000
`define GPM_DIV_RST     8'hff
`define GPM_DIV_LOW     8'h00
`define GPM_DIV_HIGH    8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define GPM_CLK_MHZ     6'd40
`define GPM_SRC_MHZ     6'd24
`define GPM_CLK_HZ      64'd40000000
`define GPM_FAST_MILLIHZ 64'd11400
`define GPM_SLOW_MILLIHZ 64'd2800

`endif

//--- src/gpm_pkg.sv
// Types shared by the pin mux.
// Assumes gpm_regs.svh for all numeric constants.
package gpm_pkg;

  // Function of pin_b0 and pin_b1
  typedef enum logic [1:0]
  {
    GPM_FN_GPIO = 2'h0,
    GPM_FN_LAMP = 2'h1,
    GPM_FN_ALT  = 2'h3,
    GPM_FN_RSVD = 2'h2
  } gpm_fn_type;

  // Per-pin pad options, one bit per pin
  typedef struct packed
  {
    logic [3:0] drv8;
    logic [3:0] inv;
    logic [3:0] pu;
    logic [3:0] od;
  } gpm_pad_cfg_type;

endpackage : gpm_pkg

//--- tb/gpm_pad_model.sv
// Far side of the pads: external drivers, pull-ups, floating pins.
// Assumes pad order b0,b1,b4,b5 and the bench clock.
`timescale 1ns/1ps
module gpm_pad_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] pad_out_i,
  input  wire logic [3:0] pad_oe_i,
  input  wire logic [3:0] pad_pu_i,
  input  wire logic [3:0] ext_en_i,
  input  wire logic [3:0] ext_val_i,
  output logic      [3:0] pad_in_o
);
  logic [3:0] churn_r;

  // Undriven pin without pull-up shows a changing level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      churn_r <= 4'h5;
    else
      churn_r <= ~churn_r;
  end

  assign pad_in_o = (pad_oe_i & pad_out_i)
                  | (~pad_oe_i & ext_en_i & ext_val_i)
                  | (~pad_oe_i & ~ext_en_i & (pad_pu_i | churn_r));
endmodule : gpm_pad_model

//--- tb/tb_gpio_function_led_clock_out.sv
// Bench for the pin mux: registers, pads, clock output, lamps, suspend.
// Assumes gpm_pad_model on the pads and lamp half periods of 20 and 50.
`timescale 1ns/1ps
`include "gpm_regs.svh"
module tb_gpio_function_led_clock_out;
  logic        clk;
  logic        rst;
  logic        psel, penable, pwrite, tx_act, rx_act, suspend, pready, pslverr, re;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [3:0]  pad_in, pad_out, pad_oe, pad_pu, pad_drv8, ext_en, ext_val;
  int          failures, compares, cycles, minhi;
  int          edg [4];

  gpm_pin_mux #(.LED_FAST_HALF(23'd20), .LED_SLOW_HALF(23'd50)) i_dut
  (
    .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TX_ACT_I(tx_act), .RX_ACT_I(rx_act),
    .SUSPEND_I(suspend), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out), .PAD_OE_O(pad_oe),
    .PAD_PU_O(pad_pu), .PAD_DRV8_O(pad_drv8)
  );

  gpm_pad_model i_pads
  (
    .clk_i(clk), .rst_i(rst), .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pad_pu_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in)
  );

  // ----------------------------------------
  // Clock, watchdog, report
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
    begin
      failures++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rq = prdata;
    re = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic watch(input int p, input int n);
    logic [3:0] prev;
    int run;
    run = 0;
    edg = '{default: 0};
    minhi = 999;
    // Let a new setting reach the pads before counting edges
    repeat (4) @(posedge clk);
    #1;
    prev = pad_out;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      for (int k = 0; k < 4; k++)
        if (pad_out[k] !== prev[k])
          edg[k]++;
      if (pad_out[p] === 1'b1 && (run > 0 || prev[p] === 1'b0))
        run++;
      else if (pad_out[p] !== 1'b1 && run > 0)
      begin
        minhi = (run < minhi) ? run : minhi;
        run = 0;
      end
      prev = pad_out;
    end
  endtask : watch

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ofs [4] = '{`GPM_FUNC_OFS, `GPM_PAD_OFS, `GPM_DIV_OFS, `GPM_GPIO_OFS};
    logic [31:0] exp [4] = '{32'h0, 32'h0, 32'hffff, 32'h0};
    check_val("oe", 32'h0, {28'h0, pad_oe});
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ofs[i], 32'h0);
      check_val("reset reg", exp[i], rq);
    end
    apb(1'b0, 8'h40, 32'h0);
    check_val("unmapped err", 32'h1, {31'h0, re});
    $display("reset test done");
  endtask : t_reset

  task automatic t_pads();
    apb(1'b1, `GPM_PAD_OFS, 32'h96c3);
    apb(1'b1, `GPM_GPIO_OFS, 32'hf9);
    {ext_en, ext_val} <= 8'h31;
    repeat (4) @(posedge clk);
    #1;
    check_val("out", 32'hc, {28'h0, pad_out});
    check_val("oe", 32'hc, {28'h0, pad_oe});
    check_val("pu", 32'hc, {28'h0, pad_pu});
    check_val("drv8", 32'h9, {28'h0, pad_drv8});
    apb(1'b0, `GPM_STAT_OFS, 32'h0);
    check_val("pad in", 32'hb, {28'h0, rq[3:0]});
    apb(1'b1, `GPM_PAD_OFS, 32'h0);
    apb(1'b1, `GPM_GPIO_OFS, 32'h0);
    ext_en <= 4'h0;
    $display("pad test done");
  endtask : t_pads

  task automatic t_clock();
    apb(1'b1, `GPM_FUNC_OFS, 32'h3);
    watch(0, 40);
    check_val("div ff level", 32'h3, {30'h0, pad_oe[0], pad_out[0]});
    check_range("div ff edges", 0, 0, edg[0]);
    apb(1'b1, `GPM_DIV_OFS, 32'h0);
    watch(0, 40);
    check_val("div 0 level", 32'h0, {31'h0, pad_out[0]});
    check_range("div 0 edges", 0, 0, edg[0]);
    apb(1'b1, `GPM_DIV_OFS, 32'h3);
    watch(0, 200);
    check_range("div 3 edges", 58, 62, edg[0]);
    apb(1'b0, `GPM_DIV_OFS, 32'h0);
    check_val("div in use", 32'h0303, rq);
    apb(1'b1, `GPM_DIV_OFS, 32'h9);
    watch(0, 400);
    check_range("div 9 edges", 45, 51, edg[0]);
    check_range("min high", 3, 999, minhi);
    apb(1'b1, `GPM_FUNC_OFS, 32'h10);
    watch(2, 200);
    check_range("b4 edges", 22, 26, edg[2]);
    check_val("b0 freed", 32'h0, {31'h0, pad_oe[0]});
    $display("clock test done");
  endtask : t_clock

  task automatic t_lamp();
    logic [31:0] fn [5] = '{32'h0d, 32'h0d, 32'h0d, 32'h05, 32'h10d};
    logic [1:0] act [5] = '{2'b00, 2'b01, 2'b10, 2'b01, 2'b01};
    int e0 [5] = '{0, 20, 0, 20, 8};
    int e1 [5] = '{0, 20, 20, 0, 8};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, `GPM_FUNC_OFS, fn[i]);
      {rx_act, tx_act} <= act[i];
      repeat (5) @(posedge clk);
      watch(0, 400);
      check_range("lamp b0", e0[i] - (e0[i] > 0), e0[i] + (e0[i] > 0), edg[0]);
      check_range("lamp b1", e1[i] - (e1[i] > 0), e1[i] + (e1[i] > 0), edg[1]);
    end
    check_val("lamp oe", 32'h3, {30'h0, pad_oe[1:0]});
    @(posedge clk);
    {rx_act, tx_act} <= 2'b00;
    $display("lamp test done");
  endtask : t_lamp

  task automatic t_suspend();
    apb(1'b1, `GPM_FUNC_OFS, 32'h0);
    apb(1'b1, `GPM_GPIO_OFS, 32'hf5);
    repeat (2) @(posedge clk);
    suspend <= 1'b1;
    apb(1'b1, `GPM_GPIO_OFS, 32'hfa);
    repeat (4) @(posedge clk);
    #1;
    check_val("kept", 32'hf5, {24'h0, pad_oe, pad_out});
    apb(1'b1, `GPM_FUNC_OFS, 32'h200);
    repeat (4) @(posedge clk);
    #1;
    check_val("float oe", 32'h0, {28'h0, pad_oe});
    @(posedge clk);
    suspend <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check_val("resume", 32'hfa, {24'h0, pad_oe, pad_out});
    $display("suspend test done");
  endtask : t_suspend

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, tx_act, rx_act, suspend, paddr, pwdata} = '0;
    {ext_en, ext_val, failures, compares, cycles} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pads();
    t_clock();
    t_lamp();
    t_suspend();
    conclude();
  end
endmodule : tb_gpio_function_led_clock_out
